// File: core/cmc_pkg.sv
// package: register map, field positions and encodings of the comparator block
`default_nettype none
package cmc_pkg;
    // ------------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL1_C1 = 4'h0;
    localparam logic [3:0] ADDR_CTRL2_C1 = 4'h1;
    localparam logic [3:0] ADDR_CTRL1_C2 = 4'h2;
    localparam logic [3:0] ADDR_CTRL2_C2 = 4'h3;
    localparam logic [3:0] ADDR_MIRROR   = 4'h4;
    localparam logic [3:0] ADDR_IRQ      = 4'h5;
    localparam logic [3:0] ADDR_ANALOG_SELECT    = 4'h6;
    localparam logic [3:0] ADDR_PORT     = 4'h7;
    localparam logic [3:0] ADDR_MISC     = 4'h8;
    localparam int         ADDR_W        = 4;
    // ------------------------------------------------------------------
    // first control register fields
    // ------------------------------------------------------------------
    localparam int BIT_ENABLE = 7;
    localparam int BIT_RESULT = 6;
    localparam int BIT_INVERT = 4;
    localparam int BIT_SPEED  = 2;
    localparam int BIT_HYST   = 1;
    localparam int BIT_SYNC   = 0;
    localparam logic [7:0] CTRL1_WMASK = 8'h97;
    localparam logic [7:0] CTRL1_RESET = 8'h04;
    // ------------------------------------------------------------------
    // second control register fields
    // ------------------------------------------------------------------
    localparam int BIT_RISE_EN = 7;
    localparam int BIT_FALL_EN = 6;
    localparam int POS_LSB     = 3;
    localparam int NEG_LSB     = 0;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    // ------------------------------------------------------------------
    // irq register: flags at 1:0, enables at 5:4
    // misc register: bit0 sleep, bit1 gate timer stops in sleep
    // ------------------------------------------------------------------
    localparam int IRQ_EN_LSB    = 4;
    localparam int BIT_SLEEP     = 0;
    localparam int BIT_TMR_HALTS = 1;
    // ------------------------------------------------------------------
    // channel encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] CH_GND     = 3'h7;
    localparam logic [2:0] CH_FIXREF  = 3'h6;
    localparam logic [2:0] CH_DAC     = 3'h5;
    localparam logic [2:0] CH_PIN0    = 3'h0;
    localparam logic [2:0] NEG_PINMAX = 3'h3;
    // instruction cycle = four system clocks
    localparam logic [1:0] ICYC_LAST  = 2'h3;
    localparam int         NCMP       = 2;
    localparam int         PORT_W     = 8;
endpackage : cmc_pkg
`default_nettype wire

// File: core/cmc_chan.sv
// one comparator channel: control regs, latching, edges, mux decode
`default_nettype none
module cmc_chan (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr1,
    input  wire logic       wr2,
    input  wire logic [7:0] wdata,
    input  wire logic       icyc_en,
    input  wire logic       raw_cmp,
    input  wire logic       tmr_fall,
    input  wire logic       tmr_run,
    output logic [7:0]      ctrl1_rd,
    output logic [7:0]      ctrl2_ff,
    output logic            result_ff,
    output logic            sync_out_ff,
    output logic            edge_event,
    output logic [3:0]      pos_onehot_ff,
    output logic [4:0]      neg_onehot_ff
);
    logic [7:0] ctrl1_ff;
    logic       prev_ff;
    logic       nxt_result;

    // ------------------------------------------------------------------
    // control registers; result bit is read-only, speed bit stays as set
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_ff <= cmc_pkg::CTRL1_RESET;
        end else if (wr1) begin
            ctrl1_ff <= wdata & cmc_pkg::CTRL1_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl2_ff <= cmc_pkg::CTRL2_RESET;
        end else if (wr2) begin
            ctrl2_ff <= wdata;
        end
    end

    // disabled core reads low; inversion applies after gating
    assign nxt_result = (raw_cmp & ctrl1_ff[cmc_pkg::BIT_ENABLE])
                      ^ ctrl1_ff[cmc_pkg::BIT_INVERT];

    // re-latch once per instruction cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            result_ff <= 1'b0;
        end else if (icyc_en) begin
            result_ff <= nxt_result;
        end
    end

    // previous latched value, same domain; taken every clock so one
    // change gives a one-cycle event and a later software clear sticks
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= result_ff;
        end
    end

    assign edge_event =
        (ctrl2_ff[cmc_pkg::BIT_RISE_EN] & result_ff & ~prev_ff)
      | (ctrl2_ff[cmc_pkg::BIT_FALL_EN] & ~result_ff & prev_ff);

    // timer-synced output holds while the timer is halted in sleep
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_out_ff <= 1'b0;
        end else if (!ctrl1_ff[cmc_pkg::BIT_SYNC]) begin
            sync_out_ff <= nxt_result;
        end else if (tmr_fall && tmr_run) begin
            sync_out_ff <= nxt_result;
        end
    end

    // mux controls: pos {pin0,dac,fixref,gnd}, neg {pin0..3 code,valid,fixref,gnd}
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_onehot_ff <= 4'h0;
            neg_onehot_ff <= 5'h00;
        end else begin
            pos_onehot_ff[0] <= ctrl2_ff[5:3] == cmc_pkg::CH_GND;
            pos_onehot_ff[1] <= ctrl2_ff[5:3] == cmc_pkg::CH_FIXREF;
            pos_onehot_ff[2] <= ctrl2_ff[5:3] == cmc_pkg::CH_DAC;
            pos_onehot_ff[3] <= ctrl2_ff[5:3] == cmc_pkg::CH_PIN0;
            neg_onehot_ff[0] <= ctrl2_ff[2:0] == cmc_pkg::CH_GND;
            neg_onehot_ff[1] <= ctrl2_ff[2:0] == cmc_pkg::CH_FIXREF;
            neg_onehot_ff[2] <= ctrl2_ff[2:0] <= cmc_pkg::NEG_PINMAX;
            neg_onehot_ff[4:3] <= ctrl2_ff[1:0];
        end
    end

    assign ctrl1_rd = ctrl1_ff | ({7'h00, result_ff} << cmc_pkg::BIT_RESULT);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_rise_sets;
        @(posedge clk) disable iff (rst)
        (icyc_en && !rst && nxt_result && !result_ff
         && ctrl2_ff[cmc_pkg::BIT_RISE_EN] && !wr2)
        |=> edge_event;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge did not raise event");

    property p_fall_sets;
        @(posedge clk) disable iff (rst)
        (edge_event && !result_ff) |-> ctrl2_ff[cmc_pkg::BIT_FALL_EN];
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling event without its enable");

    property p_latch;
        @(posedge clk) disable iff (rst)
        icyc_en |=> result_ff == $past(nxt_result);
    endproperty
    a_latch: assert property (p_latch)
        else $error("result not latched on instruction cycle");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !icyc_en |=> $stable(result_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed between instruction cycles");

    property p_async;
        @(posedge clk) disable iff (rst)
        !ctrl1_ff[cmc_pkg::BIT_SYNC] |=> sync_out_ff == $past(nxt_result);
    endproperty
    a_async: assert property (p_async)
        else $error("unsynced output does not follow");

    property p_sync_hold;
        @(posedge clk) disable iff (rst)
        (ctrl1_ff[cmc_pkg::BIT_SYNC] && !(tmr_fall && tmr_run))
        |=> $stable(sync_out_ff);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("synced output moved without timer fall");

    // no disable here: the check looks at the first edge after release
    property p_speed;
        @(posedge clk)
        $fell(rst) |-> ctrl1_ff[cmc_pkg::BIT_SPEED];
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed bit not set out of reset");

    property p_mux_gnd;
        @(posedge clk) disable iff (rst)
        (ctrl2_ff[5:3] == cmc_pkg::CH_GND) ##1 $stable(ctrl2_ff)
        |-> pos_onehot_ff == 4'h1;
    endproperty
    a_mux_gnd: assert property (p_mux_gnd)
        else $error("positive ground select not decoded");
endmodule : cmc_chan
`default_nettype wire

// File: core/cmc_top.sv
// comparator control top: register port, two channels, flags, mirror
//
// Behaviour
// - negative field picks ground, reference, none, or pins three..zero.
// - positive field picks ground, reference, converter, pin zero, else none.
// - enable bit turns comparator on; off means no active power.
// - result bit high when positive exceeds negative, reversed by inversion.
// - invert bit flips result for status and all downstream uses.
// - speed bit resets to one; zero is reserved for software.
// - hysteresis bit switches input hysteresis, reset off.
// - sync bit makes output update only on timer clock falling edge.
// - rising enable sets flag on each low-to-high result edge.
// - falling enable sets flag on each high-to-low result edge.
// - mirror register shows comparator two at bit1, one at bit0.
// - comparator runs in sleep; synced path stops if timer halts.
// - enabled comparator interrupt wakes the device from sleep.
// - active output with shutdown enable suspends waveform unit at once.
// - port reads give zero on analog pins, level on digital pins.
// - software clears flag; a simultaneous new edge keeps it set.
// - toggling invert or enable while off can raise the flag.
// - internal result is re-latched once every instruction cycle.
//
// Our own choices: the address-and-strobe port and the register offsets.
`default_nettype none
module cmc_top (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [cmc_pkg::ADDR_W-1:0]  addr,
    input  wire logic [7:0]                  wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [7:0]                  rdata,
    input  wire logic [cmc_pkg::NCMP-1:0]    raw_cmp,
    input  wire logic                        tmr_clk_src,
    input  wire logic [cmc_pkg::NCMP-1:0]    shutdown_source_enable,
    input  wire logic [cmc_pkg::PORT_W-1:0]  pin_level,
    output logic [cmc_pkg::NCMP-1:0]         cmp_out_ff,
    output logic [cmc_pkg::NCMP-1:0]         cmp_core_on_ff,
    output logic [cmc_pkg::NCMP-1:0]         hysteresis_ff,
    output logic [cmc_pkg::NCMP-1:0]         speed_ff,
    output logic [7:0]                       pos_sel_ff,
    output logic [9:0]                       neg_sel_ff,
    output logic                             shutdown_ff,
    output logic                             wake_ff,
    output logic [cmc_pkg::NCMP-1:0]         irq_flag_ff
);
    logic [1:0]  icyc_cnt_ff;
    logic        icyc_en;
    logic        tmr_prev_ff;
    logic        tmr_fall;
    logic [1:0]  irq_en_ff;
    logic [1:0]  misc_ff;
    logic [cmc_pkg::PORT_W-1:0] analog_select_ff;
    logic [1:0]  ev;
    logic [1:0]  res;
    logic [1:0]  syncv;
    logic [7:0]  c1rd [2];
    logic [7:0]  c2rd [2];
    logic [3:0]  posoh [2];
    logic [4:0]  negoh [2];
    logic        wr_irq;
    logic [7:0]  nxt_rdata;

    // ------------------------------------------------------------------
    // instruction-cycle enable: one pulse every four system clocks
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            icyc_cnt_ff <= 2'h0;
        end else begin
            icyc_cnt_ff <= icyc_cnt_ff + 2'h1;
        end
    end
    assign icyc_en = icyc_cnt_ff == cmc_pkg::ICYC_LAST;

    // timer clock source sampled as a synchronous level
    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_prev_ff <= 1'b0;
        end else begin
            tmr_prev_ff <= tmr_clk_src;
        end
    end
    assign tmr_fall = tmr_prev_ff & ~tmr_clk_src;

    // ------------------------------------------------------------------
    // the two comparator channels
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < cmc_pkg::NCMP; gi++) begin : g_ch
            cmc_chan u_ch (
                .clk           (clk),
                .rst           (rst),
                .wr1           (wr_en && addr == 4'(2 * gi)),
                .wr2           (wr_en && addr == 4'(2 * gi + 1)),
                .wdata         (wdata),
                .icyc_en       (icyc_en),
                .raw_cmp       (raw_cmp[gi]),
                .tmr_fall      (tmr_fall),
                .tmr_run       (!(misc_ff[cmc_pkg::BIT_SLEEP]
                                && misc_ff[cmc_pkg::BIT_TMR_HALTS])),
                .ctrl1_rd      (c1rd[gi]),
                .ctrl2_ff      (c2rd[gi]),
                .result_ff     (res[gi]),
                .sync_out_ff   (syncv[gi]),
                .edge_event    (ev[gi]),
                .pos_onehot_ff (posoh[gi]),
                .neg_onehot_ff (negoh[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // software-set config: irq enables, sleep state, analog select
    // ------------------------------------------------------------------
    assign wr_irq = wr_en && addr == cmc_pkg::ADDR_IRQ;
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_en_ff <= 2'h0;
        end else if (wr_irq) begin
            irq_en_ff <= wdata[cmc_pkg::IRQ_EN_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            misc_ff <= 2'h0;
        end else if (wr_en && addr == cmc_pkg::ADDR_MISC) begin
            misc_ff <= wdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            analog_select_ff <= '1;
        end else if (wr_en && addr == cmc_pkg::ADDR_ANALOG_SELECT) begin
            analog_select_ff <= wdata;
        end
    end

    // flags: writing 1 clears, a same-cycle edge wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_flag_ff <= 2'h0;
        end else begin
            irq_flag_ff <= (irq_flag_ff & ~({2{wr_irq}} & wdata[1:0]))
                         | ev;
        end
    end

    // wake only while the matching enable is set
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= misc_ff[cmc_pkg::BIT_SLEEP]
                     && |(irq_flag_ff & irq_en_ff);
        end
    end

    // ------------------------------------------------------------------
    // outputs toward analog cores, timer, pin and waveform unit
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_out_ff     <= 2'h0;
            cmp_core_on_ff <= 2'h0;
            hysteresis_ff  <= 2'h0;
            speed_ff       <= 2'h3;
            pos_sel_ff     <= 8'h00;
            neg_sel_ff     <= 10'h000;
            shutdown_ff    <= 1'b0;
        end else begin
            cmp_out_ff     <= syncv;
            cmp_core_on_ff <= {c1rd[1][cmc_pkg::BIT_ENABLE],
                               c1rd[0][cmc_pkg::BIT_ENABLE]};
            hysteresis_ff  <= {c1rd[1][cmc_pkg::BIT_HYST],
                               c1rd[0][cmc_pkg::BIT_HYST]};
            speed_ff       <= {c1rd[1][cmc_pkg::BIT_SPEED],
                               c1rd[0][cmc_pkg::BIT_SPEED]};
            pos_sel_ff     <= {posoh[1], posoh[0]};
            neg_sel_ff     <= {negoh[1], negoh[0]};
            shutdown_ff    <= |(syncv & shutdown_source_enable);
        end
    end

    // ------------------------------------------------------------------
    // register read, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (addr)
            cmc_pkg::ADDR_CTRL1_C1: nxt_rdata = c1rd[0];
            cmc_pkg::ADDR_CTRL2_C1: nxt_rdata = c2rd[0];
            cmc_pkg::ADDR_CTRL1_C2: nxt_rdata = c1rd[1];
            cmc_pkg::ADDR_CTRL2_C2: nxt_rdata = c2rd[1];
            cmc_pkg::ADDR_MIRROR:   nxt_rdata = {6'h00, res};
            cmc_pkg::ADDR_IRQ:      nxt_rdata = {2'h0, irq_en_ff,
                                                 2'h0, irq_flag_ff};
            cmc_pkg::ADDR_ANALOG_SELECT:    nxt_rdata = analog_select_ff;
            cmc_pkg::ADDR_PORT:     nxt_rdata = pin_level & ~analog_select_ff;
            cmc_pkg::ADDR_MISC:     nxt_rdata = {6'h00, misc_ff};
            default:                nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_en ? nxt_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flag_wins;
        @(posedge clk) disable iff (rst)
        ev[0] |=> irq_flag_ff[0];
    endproperty
    a_flag_wins: assert property (p_flag_wins)
        else $error("edge lost against clear");

    property p_mirror;
        @(posedge clk) disable iff (rst)
        (rd_en && addr == cmc_pkg::ADDR_MIRROR)
        |=> rdata == {6'h00, $past(res)};
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror register wrong");

    property p_port;
        @(posedge clk) disable iff (rst)
        (rd_en && addr == cmc_pkg::ADDR_PORT)
        |=> (rdata & $past(analog_select_ff)) == 8'h00;
    endproperty
    a_port: assert property (p_port)
        else $error("analog pin read nonzero");

    property p_shutdown;
        @(posedge clk) disable iff (rst)
        |(syncv & shutdown_source_enable) |=> shutdown_ff;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown not raised");

    property p_wake;
        @(posedge clk) disable iff (rst)
        wake_ff |-> $past(|(irq_flag_ff & irq_en_ff));
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without enabled flag");
endmodule : cmc_top
`default_nettype wire

// File: sim/cmc_analog_model.sv
// behavioural analog cores and input multiplexers behind the control block
`default_nettype none
module cmc_analog_model (
    input  wire logic [1:0]  core_on,
    input  wire logic [7:0]  pos_sel,
    input  wire logic [9:0]  neg_sel,
    input  wire logic [7:0]  vp0,
    input  wire logic [7:0]  vdac,
    input  wire logic [7:0]  vref,
    input  wire logic [31:0] vn_pins,
    output logic      [1:0]  raw
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // one core; bit 8 marks a connected input
    // ------------------------------------------------------------------
    // an open input never wins, so a bad decode shows as a stuck result
    function automatic logic core(input logic       on,
                                  input logic [3:0] ps,
                                  input logic [4:0] ns);
        logic [8:0] p;
        logic [8:0] n;
        p = ps[3] ? {1'b1, vp0} : ps[2] ? {1'b1, vdac} :
            ps[1] ? {1'b1, vref} : ps[0] ? 9'h100 : 9'h000;
        n = ns[2] ? {1'b1, vn_pins[{ns[4:3], 3'h0} +: 8]} :
            ns[1] ? {1'b1, vref} : ns[0] ? 9'h100 : 9'h000;
        return on & p[8] & n[8] & (p[7:0] > n[7:0]);
    endfunction : core
    // both cores settle at once, no response time modelled
    always_comb begin
        raw[0] = core(core_on[0], pos_sel[3:0], neg_sel[4:0]);
        raw[1] = core(core_on[1], pos_sel[7:4], neg_sel[9:5]);
    end
endmodule : cmc_analog_model
`default_nettype wire

// File: sim/cmc_top_test.sv
// self-checking bench for the comparator control block
`default_nettype none
module cmc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, wr_en, rd_en, tmr_clk_src, shutdown_ff, wake_ff;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pin_level, pos_sel_ff, vp0, rd_val;
    logic [1:0] raw_cmp, sse, cmp_out_ff, core_on, hyst, speed, irq;
    logic [9:0] neg_sel_ff;
    int         mismatches, checked;
    cmc_top u_cmc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .raw_cmp(raw_cmp),
        .tmr_clk_src(tmr_clk_src), .shutdown_source_enable(sse),
        .pin_level(pin_level), .cmp_out_ff(cmp_out_ff),
        .cmp_core_on_ff(core_on), .hysteresis_ff(hyst), .speed_ff(speed),
        .pos_sel_ff(pos_sel_ff), .neg_sel_ff(neg_sel_ff),
        .shutdown_ff(shutdown_ff), .wake_ff(wake_ff), .irq_flag_ff(irq));
    // all negative pins sit above vp0's low setting
    cmc_analog_model u_cmc_analog_model (.core_on(core_on),
        .pos_sel(pos_sel_ff), .neg_sel(neg_sel_ff), .vp0(vp0),
        .vdac(8'h20), .vref(8'h30), .vn_pins(32'h80808080), .raw(raw_cmp));
    // ------------------------------------------------------------------
    // bus tasks and compares
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic chk_port(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: port %h, want %h", $time, got, exp);
        end
    endtask : chk_port
    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rd_val = rdata;
        checked++;
        if (rd_val !== exp) begin
            mismatches++;
            $display("wrong value at %0t: reg %h read %h, want %h",
                     $time, a, rd_val, exp);
        end
    endtask : chk_reg
    function automatic logic [3:0] pos_exp(input logic [2:0] c);
        case (c)
            3'h7:    return 4'h1;
            3'h6:    return 4'h2;
            3'h5:    return 4'h4;
            3'h0:    return 4'h8;
            default: return 4'h0;
        endcase
    endfunction : pos_exp
    function automatic logic [4:0] neg_exp(input logic [2:0] c);
        case (c)
            3'h7:       return {c[1:0], 3'h1};
            3'h6:       return {c[1:0], 3'h2};
            3'h5, 3'h4: return {c[1:0], 3'h0};
            default:    return {c[1:0], 3'h4};
        endcase
    endfunction : neg_exp
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // whole sequence is some 200 cycles, so this only cuts a hang
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {wr_en, rd_en, addr, wdata, sse} = '0;
        mismatches = 0;
        checked = 0;
        rst = 1'b1;
        tmr_clk_src = 1'b1;
        pin_level = 8'hA5;
        vp0 = 8'h40;
        tick(3);
        rst <= 1'b0;
        chk_reg(cmc_pkg::ADDR_CTRL1_C1, 8'h04);
        chk_reg(cmc_pkg::ADDR_CTRL2_C1, 8'h00);
        chk_reg(cmc_pkg::ADDR_MIRROR, 8'h00);
        chk_reg(4'hF, 8'h00);
        chk_port({8'h0, speed}, 10'h003);
        for (int c = 0; c < 8; c++) begin
            wr(cmc_pkg::ADDR_CTRL2_C1, {2'h0, c[2:0], c[2:0]});
            tick(2);
            #1 chk_port({6'h0, pos_sel_ff[3:0]}, {6'h0, pos_exp(c[2:0])});
            chk_port({5'h0, neg_sel_ff[4:0]}, {5'h0, neg_exp(c[2:0])});
        end
        // pin zero on both inputs, rising edges armed; speed kept at one
        wr(cmc_pkg::ADDR_CTRL2_C1, 8'h80);
        wr(cmc_pkg::ADDR_CTRL1_C1, 8'h86);
        tick(10);
        #1 chk_port({6'h0, core_on, hyst}, 10'h005);
        chk_reg(cmc_pkg::ADDR_CTRL1_C1, 8'h86);
        vp0 <= 8'hC0;
        tick(10);
        #1 chk_port({6'h0, irq, cmp_out_ff}, 10'h005);
        chk_port({9'h0, wake_ff}, 10'h000);
        chk_reg(cmc_pkg::ADDR_MIRROR, 8'h01);
        chk_reg(cmc_pkg::ADDR_CTRL1_C1, 8'hC6);
        sse <= 2'h1;
        tick(3);
        #1 chk_port({9'h0, shutdown_ff}, 10'h001);
        sse <= 2'h2;
        tick(3);
        #1 chk_port({9'h0, shutdown_ff}, 10'h000);
        wr(cmc_pkg::ADDR_IRQ, 8'h11);
        vp0 <= 8'h40;
        tick(10);
        #1 chk_port({8'h0, irq}, 10'h000);
        wr(cmc_pkg::ADDR_CTRL2_C1, 8'h40);
        vp0 <= 8'hC0;
        tick(10);
        #1 chk_port({8'h0, irq}, 10'h000);
        wr(cmc_pkg::ADDR_MISC, 8'h01);
        vp0 <= 8'h40;
        tick(10);
        #1 chk_port({7'h0, irq, wake_ff}, 10'h003);
        wr(cmc_pkg::ADDR_MISC, 8'h00);
        // off core, then the invert bit alone makes a rising edge
        wr(cmc_pkg::ADDR_IRQ, 8'h01);
        wr(cmc_pkg::ADDR_CTRL1_C1, 8'h04);
        wr(cmc_pkg::ADDR_CTRL2_C1, 8'h80);
        wr(cmc_pkg::ADDR_CTRL1_C1, 8'h14);
        tick(10);
        #1 chk_port({8'h0, irq}, 10'h001);
        chk_reg(cmc_pkg::ADDR_CTRL1_C1, 8'h54);
        // synced output moves only on a timer clock fall
        wr(cmc_pkg::ADDR_IRQ, 8'h01);
        wr(cmc_pkg::ADDR_CTRL1_C1, 8'h85);
        tick(6);
        tmr_clk_src <= 1'b0;
        tick(6);
        tmr_clk_src <= 1'b1;
        vp0 <= 8'hC0;
        tick(10);
        #1 chk_port({8'h0, cmp_out_ff}, 10'h000);
        chk_reg(cmc_pkg::ADDR_CTRL1_C1, 8'hC5);
        tick(1);
        tmr_clk_src <= 1'b0;
        tick(6);
        #1 chk_port({8'h0, cmp_out_ff}, 10'h001);
        // second comparator: reset channels pick pin zero on both inputs
        wr(cmc_pkg::ADDR_CTRL1_C2, 8'h84);
        tick(10);
        #1 chk_port({6'h0, pos_sel_ff[7:4]}, 10'h008);
        chk_port({5'h0, neg_sel_ff[9:5]}, 10'h004);
        chk_port({6'h0, irq, cmp_out_ff}, 10'h007);
        chk_reg(cmc_pkg::ADDR_MIRROR, 8'h03);
        chk_reg(cmc_pkg::ADDR_PORT, 8'h00);
        wr(cmc_pkg::ADDR_ANALOG_SELECT, 8'h0F);
        chk_reg(cmc_pkg::ADDR_PORT, 8'hA0);
        tally_and_finish();
    end
endmodule : cmc_top_test
`default_nettype wire
